// ===== tbfc_defs.svh
// Purpose: Constants for the block-format tape controller.
// Assumes: Included by the top module.
// Notes:   Offsets are APB byte addresses within the block.
`ifndef TBFC_DEFS_SVH
`define TBFC_DEFS_SVH

// Register offsets.
`define TBFC_CTRL_OFS     12'h000
`define TBFC_BLOCK_OFS    12'h004
`define TBFC_STATUS_OFS   12'h008

// Control register fields.
`define TBFC_CTRL_START   0
`define TBFC_CTRL_HALT    1
`define TBFC_CTRL_UNIT    2
`define TBFC_CTRL_REV     5
`define TBFC_CTRL_ESTOP   6
`define TBFC_CTRL_OP      7
`define TBFC_CTRL_NOPAUSE 9
`define TBFC_CTRL_QUART   10

// Status register fields.
`define TBFC_ST_BUSY      0
`define TBFC_ST_DONE      1
`define TBFC_ST_CKSERR    2
`define TBFC_ST_END       3
`define TBFC_ST_HALTED    4
`define TBFC_ST_TURN      5
`define TBFC_ST_CLASS     8
`define TBFC_ST_BLOCK     16

// Tape format figures.
`define TBFC_WORD_BITS    12
`define TBFC_LINE_BITS    3
`define TBFC_LINES        4
`define TBFC_BLOCK_WORDS  256
`define TBFC_DATA_BLOCKS  12'h200
`define TBFC_TURN_HI_LO   12'h200
`define TBFC_TURN_HI_HI   12'h20C
`define TBFC_TURN_LO_LO   12'hFF8

// Mark channel codes, four lines per word.
`define TBFC_MK_END       4'h0
`define TBFC_MK_INTER     4'hF
`define TBFC_MK_BLOCK     4'hE
`define TBFC_MK_RBLOCK    4'h7
`define TBFC_MK_GUARD     4'h2
`define TBFC_MK_DATA      4'h9
`define TBFC_MK_FINAL     4'hB
`define TBFC_MK_CHECK     4'h1

`endif

// ===== tbfc_pkg.sv
// Purpose: Types shared by the tape controller.
// Assumes: Constants come from tbfc_defs.svh.
// Notes:   Command and result structs carry grouped fields across the clock crossing.
package tbfc_pkg;

	typedef enum logic [1:0] {TBFC_OP_READ = 2'h0, TBFC_OP_WRITE = 2'h1, TBFC_OP_CHECK = 2'h2} tbfc_op_t;

	typedef enum logic [2:0] {
		TBFC_IDLE   = 3'h0,
		TBFC_SEARCH = 3'h1,
		TBFC_GUARD  = 3'h3,
		TBFC_XFER   = 3'h2,
		TBFC_CKSUM  = 3'h6,
		TBFC_FINISH = 3'h7
	} tbfc_state_t;

	typedef struct packed {
		logic [2:0] unit;
		logic       reverse;
		logic       end_stop;
		tbfc_op_t   op;
		logic       no_pause;
		logic [2:0] quarter;
		logic [8:0] block;
	} tbfc_cmd_t;

	typedef struct packed {
		logic        end_seen;
		logic        cks_err;
		logic        halted;
		logic        turn_seen;
		logic [1:0]  last_class;
		logic [11:0] last_block;
	} tbfc_result_t;

	typedef struct packed {
		logic [2:0] unit;
		logic       fwd;
		logic       rev;
		logic       go;
		logic       stop;
		logic       all_halt;
	} tbfc_motion_t;

endpackage

// ===== tbfc_top.sv
// Purpose: Block-format tape controller: APB registers, cycle-steal memory port, tape link logic.
// Assumes: link_clk samples the tape; tape pins are asynchronous; memory answers mem_req with mem_ack.
// Notes:   Function
`timescale 1ns/1ns
`include "tbfc_defs.svh"

module tbfc_top
	import tbfc_pkg::*;
	#(
	parameter int BLOCK_WORDS = `TBFC_BLOCK_WORDS
	)
	(
	// Core clock, reset and freeze.
	input  wire logic         core_clk,
	input  wire logic         srst,
	input  wire logic         core_ce,
	// APB slave.
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic      [31:0]  prdata,
	output logic              pready,
	output logic              pslverr,
	// Cycle-steal memory port and processor stall.
	output logic              mem_req,
	output logic              mem_we,
	output logic      [11:0]  mem_addr,
	output logic      [11:0]  mem_wdata,
	input  wire logic [11:0]  mem_rdata,
	input  wire logic         mem_ack,
	output logic              cpu_stall,
	// Tape link.
	input  wire logic         link_clk,
	input  wire logic [1:0]   tape_timing,
	input  wire logic [1:0]   tape_mark,
	input  wire logic [5:0]   tape_data_in,
	input  wire logic         tape_wr_enable_n,
	output tbfc_motion_t      tape_motion,
	output logic              tape_wr_current,
	output logic      [2:0]   tape_wr_data
	);

	// Core-side state.
	tbfc_cmd_t    cmd;
	tbfc_result_t res_core;
	logic         busy;
	logic         done;
	logic         started;
	logic         halt_req;
	logic         start_tgl;
	logic         wresp_tgl;
	logic [7:0]   word_idx;
	logic [11:0]  core_wdata;
	logic [2:0]   csync1;
	logic [2:0]   csync2;
	logic [2:0]   csync3;

	// Link-side state.
	tbfc_state_t  state;
	tbfc_state_t  next_state;
	tbfc_cmd_t    lcmd;
	tbfc_result_t res_link;
	logic [10:0]  pin1;
	logic [10:0]  pin2;
	logic [4:0]   lsync1;
	logic [4:0]   lsync2;
	logic         tim_q;
	logic [1:0]   tgl_q;
	logic [11:0]  word_assembly_buffer;
	logic [3:0]   win;
	logic [1:0]   line_cnt;
	logic [8:0]   word_cnt;
	logic [11:0]  sum;
	logic [11:0]  link_word;
	logic         word_tgl;
	logic         done_tgl;
	logic         ack_tgl;
	logic         dir_rev;
	logic         go_lvl;
	logic         write_on;

	// APB decode.
	wire logic setup     = psel & ~penable;
	wire logic access_ok = psel & penable & pready;
	wire logic hit_ctrl  = paddr == `TBFC_CTRL_OFS;
	wire logic hit_block = paddr == `TBFC_BLOCK_OFS;
	wire logic hit_stat  = paddr == `TBFC_STATUS_OFS;
	wire logic wr_ctrl   = access_ok & pwrite & hit_ctrl;
	wire logic wr_block  = access_ok & pwrite & hit_block & ~busy;
	wire logic wr_stat   = access_ok & pwrite & hit_stat;
	wire logic go_start  = wr_ctrl & pwdata[`TBFC_CTRL_START] & ~busy;

	// Events arriving from the link after two flip-flops.
	wire logic ev_word   = csync2[0] ^ csync3[0];
	wire logic ev_done   = csync2[1] ^ csync3[1];
	wire logic ev_ack    = csync2[2] ^ csync3[2];

	// Read-back values.
	wire logic [31:0] ctrl_rd = {19'h0, cmd.quarter, cmd.no_pause, cmd.op, cmd.end_stop,
		cmd.reverse, cmd.unit, halt_req, 1'b0};
	wire logic [31:0] stat_rd = {4'h0, res_core.last_block, 6'h0, res_core.last_class, 2'h0,
		res_core.turn_seen, res_core.halted, res_core.end_seen, res_core.cks_err, done, busy};
	wire logic [31:0] rd_mux  = hit_ctrl ? ctrl_rd : hit_block ? {23'h0, cmd.block} :
		hit_stat ? stat_rd : 32'h0;

	// APB answer: ready in the first access cycle, so every transfer is two cycles.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end
		else if (core_ce)
		begin
			pready  <= setup;
			pslverr <= setup & ~(hit_ctrl | hit_block | hit_stat);
			prdata  <= setup & ~pwrite ? rd_mux : 32'h0;
		end
	end

	// Command and status registers; the command is frozen while busy so the link sees it stable.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			cmd       <= '0;
			halt_req  <= 1'b0;
			busy      <= 1'b0;
			done      <= 1'b0;
			started   <= 1'b0;
			start_tgl <= 1'b0;
			res_core  <= '0;
		end
		else if (core_ce)
		begin
			if (wr_ctrl)
				halt_req <= pwdata[`TBFC_CTRL_HALT];
			if (wr_ctrl & ~busy)
			begin
				cmd.unit     <= pwdata[`TBFC_CTRL_UNIT +: 3];
				cmd.reverse  <= pwdata[`TBFC_CTRL_REV];
				cmd.end_stop <= pwdata[`TBFC_CTRL_ESTOP];
				cmd.op       <= tbfc_op_t'(pwdata[`TBFC_CTRL_OP +: 2]);
				cmd.no_pause <= pwdata[`TBFC_CTRL_NOPAUSE];
				cmd.quarter  <= pwdata[`TBFC_CTRL_QUART +: 3];
			end
			if (wr_block)
				cmd.block <= pwdata[8:0];
			if (go_start)
			begin
				busy      <= 1'b1;
				started   <= 1'b0;
				start_tgl <= ~start_tgl;
			end
			else if (ev_done)
				busy <= 1'b0;
			if (ev_ack)
				started <= 1'b1;
			// A completion in the same cycle as the clear keeps the flag set.
			if (ev_done)
			begin
				done     <= 1'b1;
				res_core <= res_link;
			end
			else if (wr_stat & pwdata[`TBFC_ST_DONE])
				done <= 1'b0;
		end
	end

	// Processor stall: whole operation by default, only until start in no-pause mode.
	always_ff @(posedge core_clk)
	begin
		if (srst)
			cpu_stall <= 1'b0;
		else if (core_ce)
			cpu_stall <= (go_start | busy & ~ev_done) & ~(cmd.no_pause & (started | ev_ack));
	end

	// Cycle stealing: one memory cycle per word the link asks for.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			mem_req    <= 1'b0;
			mem_we     <= 1'b0;
			mem_addr   <= 12'h000;
			mem_wdata  <= 12'h000;
			word_idx   <= 8'h00;
			core_wdata <= 12'h000;
			wresp_tgl  <= 1'b0;
		end
		else if (core_ce)
		begin
			if (go_start)
				word_idx <= 8'h00;
			if (ev_word)
			begin
				mem_req   <= 1'b1;
				mem_we    <= cmd.op == TBFC_OP_READ;
				mem_addr  <= {1'b0, cmd.quarter, word_idx};
				mem_wdata <= link_word;
			end
			else if (mem_req & mem_ack)
			begin
				mem_req   <= 1'b0;
				word_idx  <= word_idx + 8'h01;
				wresp_tgl <= ~wresp_tgl;
				if (!mem_we)
					core_wdata <= mem_rdata;
			end
		end
	end

	// Link toggles into the core domain: two flip-flops, then an edge compare.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			csync1 <= 3'h0;
			csync2 <= 3'h0;
			csync3 <= 3'h0;
		end
		else if (core_ce)
		begin
			csync1 <= {ack_tgl, done_tgl, word_tgl};
			csync2 <= csync1;
			csync3 <= csync2;
		end
	end

	// Link side: pins and core controls pass two flip-flops; reset and freeze included.
	always_ff @(posedge link_clk)
	begin
		pin1   <= {tape_timing, tape_mark, tape_data_in, tape_wr_enable_n};
		pin2   <= pin1;
		lsync1 <= {srst, core_ce, halt_req, start_tgl, wresp_tgl};
		lsync2 <= lsync1;
	end

	wire logic       lrst      = lsync2[4];
	wire logic       lce       = lsync2[3];
	wire logic       lhalt     = lsync2[2];
	// Redundant pairs are combined after synchronising, as series heads would be.
	wire logic       tim       = |pin2[10:9];
	wire logic       mark      = |pin2[8:7];
	// Channel 1 carries the oldest bit of each line, so it lands highest in the word.
	wire logic [2:0] line      = {|pin2[2:1], |pin2[4:3], |pin2[6:5]};
	wire logic       wr_en     = ~pin2[0];
	// Each rising timing edge is one line strobe; data is sampled in its late phase.
	wire logic       strobe    = tim & ~tim_q;
	wire logic       ev_start  = lsync2[1] ^ tgl_q[1];
	wire logic       ev_wresp  = lsync2[0] ^ tgl_q[0];
	wire logic [3:0] win_next  = {win[2:0], mark};
	wire logic       realign   = (state == TBFC_IDLE || state == TBFC_SEARCH) && win_next == `TBFC_MK_BLOCK;
	wire logic       boundary  = strobe & (line_cnt == 2'h3 | realign);
	wire logic [11:0] rwb_in   = {word_assembly_buffer[8:0], line};
	wire logic       writing   = lcmd.op == TBFC_OP_WRITE;
	wire logic       is_data   = win_next == `TBFC_MK_DATA || win_next == `TBFC_MK_FINAL;
	wire logic       last_word = writing ? word_cnt == 9'(BLOCK_WORDS - 1) : win_next == `TBFC_MK_FINAL;
	wire logic       in_turn   = rwb_in >= `TBFC_TURN_LO_LO ||
		(rwb_in >= `TBFC_TURN_HI_LO && rwb_in <= `TBFC_TURN_HI_HI);
	wire logic       fwd_hit   = win_next == `TBFC_MK_BLOCK & ~dir_rev & rwb_in == {3'h0, lcmd.block};
	wire logic       end_zone  = win_next == `TBFC_MK_END;
	wire logic       moving    = state != TBFC_IDLE && state != TBFC_FINISH;

	// Mark classification of the finished word.
	wire logic [1:0] word_class = is_data ? 2'h0 :
		(win_next == `TBFC_MK_BLOCK || win_next == `TBFC_MK_RBLOCK) ? 2'h1 : 2'h2;

	// Next state of the link sequencer.
	always_comb
	begin
		next_state = state;
		unique case (state)
			TBFC_IDLE:   if (ev_start) next_state = TBFC_SEARCH;
			TBFC_SEARCH:
				if (boundary & end_zone & lcmd.end_stop)
					next_state = TBFC_FINISH;
				else if (boundary & fwd_hit & ~in_turn)
					next_state = TBFC_GUARD;
			TBFC_GUARD:  if (boundary) next_state = TBFC_XFER;
			TBFC_XFER:   if (boundary & last_word & (writing | is_data)) next_state = TBFC_CKSUM;
			TBFC_CKSUM:  if (boundary) next_state = TBFC_FINISH;
			TBFC_FINISH: next_state = TBFC_IDLE;
		endcase
		if (lhalt && state != TBFC_IDLE && state != TBFC_FINISH)
			next_state = TBFC_FINISH;
	end

	// Sequencer, word assembly and checksum.
	always_ff @(posedge link_clk)
	begin
		if (lrst)
		begin
			state     <= TBFC_IDLE;
			tim_q     <= 1'b0;
			tgl_q     <= 2'h0;
			lcmd      <= '0;
			res_link  <= '0;
			word_assembly_buffer       <= 12'h000;
			win       <= 4'h0;
			line_cnt  <= 2'h0;
			word_cnt  <= 9'h000;
			sum       <= 12'h000;
			link_word <= 12'h000;
			word_tgl  <= 1'b0;
			done_tgl  <= 1'b0;
			ack_tgl   <= 1'b0;
			dir_rev   <= 1'b0;
		end
		else if (lce)
		begin
			state <= next_state;
			tim_q <= tim;
			tgl_q <= lsync2[1:0];
			if (ev_start && state == TBFC_IDLE)
			begin
				lcmd     <= cmd;
				dir_rev  <= cmd.reverse;
				res_link <= '0;
				ack_tgl  <= ~ack_tgl;
				if (cmd.op == TBFC_OP_WRITE)
					word_tgl <= ~word_tgl;
			end
			if (strobe)
			begin
				win      <= win_next;
				line_cnt <= boundary ? 2'h0 : line_cnt + 2'h1;
				word_assembly_buffer      <= (state == TBFC_XFER || state == TBFC_CKSUM) && writing ? {word_assembly_buffer[8:0], 3'h0} : rwb_in;
			end
			if (boundary)
			begin
				res_link.last_class <= word_class;
				if (win_next == `TBFC_MK_BLOCK)
				begin
					res_link.last_block <= rwb_in;
					res_link.turn_seen  <= res_link.turn_seen | in_turn;
				end
				if (state == TBFC_SEARCH && end_zone && !lcmd.end_stop)
					dir_rev <= ~dir_rev;
				if (state == TBFC_SEARCH && end_zone)
					res_link.end_seen <= 1'b1;
				if (state == TBFC_SEARCH && dir_rev && win_next == `TBFC_MK_RBLOCK && rwb_in < {3'h0, lcmd.block})
					dir_rev <= 1'b0;
				if (state == TBFC_GUARD)
				begin
					word_cnt <= 9'h000;
					sum      <= 12'h000;
					if (writing)
					begin
						word_assembly_buffer       <= core_wdata;
						link_word <= core_wdata;
						word_tgl  <= ~word_tgl;
					end
				end
				// The word after next is fetched here, so it has a whole word time to arrive.
				if (state == TBFC_XFER && writing)
				begin
					word_cnt  <= word_cnt + 9'h001;
					sum       <= sum + link_word;
					word_assembly_buffer       <= last_word ? ~(sum + link_word) : core_wdata;
					link_word <= core_wdata;
					if (word_cnt < 9'(BLOCK_WORDS - 2))
						word_tgl <= ~word_tgl;
				end
				if (state == TBFC_XFER && !writing && is_data)
				begin
					sum <= sum + rwb_in;
					if (lcmd.op == TBFC_OP_READ)
					begin
						link_word <= rwb_in;
						word_tgl  <= ~word_tgl;
					end
				end
				if (state == TBFC_CKSUM && !writing)
					res_link.cks_err <= rwb_in != ~sum;
			end
			if (lhalt && state != TBFC_IDLE)
				res_link.halted <= 1'b1;
			if (state == TBFC_FINISH)
				done_tgl <= ~done_tgl;
		end
	end

	// Transport control levels, always complementary.
	always_ff @(posedge link_clk)
	begin
		if (lrst)
		begin
			tape_motion <= '{unit: 3'h0, fwd: 1'b1, rev: 1'b0, go: 1'b0, stop: 1'b1, all_halt: 1'b0};
			go_lvl      <= 1'b0;
		end
		else if (lce)
		begin
			go_lvl               <= moving & ~lhalt;
			tape_motion.unit     <= lcmd.unit;
			tape_motion.fwd      <= ~dir_rev;
			tape_motion.rev      <= dir_rev;
			tape_motion.go       <= go_lvl;
			tape_motion.stop     <= ~go_lvl;
			tape_motion.all_halt <= lhalt;
		end
	end

	// Write head drive: phase encoding against the timing level, gated by write enable.
	always_ff @(posedge link_clk)
	begin
		if (lrst)
		begin
			write_on        <= 1'b0;
			tape_wr_current <= 1'b0;
			tape_wr_data    <= 3'h0;
		end
		else if (lce)
		begin
			write_on        <= writing && (state == TBFC_XFER || state == TBFC_CKSUM);
			tape_wr_current <= write_on & wr_en;
			tape_wr_data    <= write_on & wr_en ? word_assembly_buffer[11:9] ^ {3{tim}} : 3'h0;
		end
	end

endmodule

// ===== tbfc_top_sva.sv
// Purpose: Port assertions for the tape controller.
// Assumes: Bound to tbfc_top; srst guards both clock domains.
// Notes:   Core and link properties each name their own clock.
`timescale 1ns/1ns
module tbfc_sva
	import tbfc_pkg::*;
	(
	// Core side.
	input wire logic         core_clk,
	input wire logic         srst,
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pready,
	input wire logic         pslverr,
	input wire logic         mem_req,
	input wire logic         mem_ack,
	input wire logic [11:0]  mem_addr,
	input wire logic         mem_we,
	// Link side.
	input wire logic         link_clk,
	input wire logic         tape_wr_enable_n,
	input wire tbfc_motion_t tape_motion,
	input wire logic         tape_wr_current
	);
	// A setup cycle is answered in the next cycle, and the answer lasts one cycle only.
	property p_ready_next; @(posedge core_clk) disable iff (srst) psel && !penable |=> pready; endproperty
	a_ready_next: assert property (p_ready_next) else $error("No ready after setup.");
	property p_ready_once; @(posedge core_clk) disable iff (srst) pready |=> !pready; endproperty
	a_ready_once: assert property (p_ready_once) else $error("Ready held too long.");
	property p_err_pair; @(posedge core_clk) disable iff (srst) pslverr |-> pready && penable; endproperty
	a_err_pair: assert property (p_err_pair) else $error("Error without ready.");
	// A stolen cycle keeps its request steady until memory answers, then lets go.
	property p_mem_hold;
		@(posedge core_clk) disable iff (srst) mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
	endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("Memory request moved early.");
	property p_mem_drop; @(posedge core_clk) disable iff (srst) mem_req && mem_ack |=> !mem_req; endproperty
	a_mem_drop: assert property (p_mem_drop) else $error("Memory request not released.");
	// Motion levels are complementary pairs at all times.
	property p_dir; @(posedge link_clk) disable iff (srst) tape_motion.fwd != tape_motion.rev; endproperty
	a_dir: assert property (p_dir) else $error("Direction levels equal.");
	property p_go; @(posedge link_clk) disable iff (srst) tape_motion.go != tape_motion.stop; endproperty
	a_go: assert property (p_go) else $error("Go levels equal.");
	// Write current needs a granted enable; the synchroniser allows a few cycles of lag.
	property p_wcur; @(posedge link_clk) disable iff (srst) tape_wr_enable_n [*5] |-> !tape_wr_current; endproperty
	a_wcur: assert property (p_wcur) else $error("Write current without enable.");
	c_store: cover property (@(posedge core_clk) mem_req && mem_ack && mem_we);
	c_fetch: cover property (@(posedge core_clk) mem_req && mem_ack && !mem_we);
	c_halt: cover property (@(posedge link_clk) tape_motion.all_halt);
endmodule

// ===== tbfc_tape_model.sv
// Purpose: Behavioural tape transport carrying a standard block layout.
// Assumes: The selected unit streams forward only while go is high.
// Notes:   Data word i of every block is seed XOR 13*i; written lines are not decoded.
`timescale 1ns/1ns
module tbfc_tape_model
	import tbfc_pkg::*;
	(
	// Link clock and transport commands.
	input  wire logic         link_clk,
	input  wire tbfc_motion_t tape_motion,
	// Scenario controls.
	input  wire logic [2:0]   sel_unit,
	input  wire logic [11:0]  blk,
	input  wire logic [11:0]  seed,
	input  wire logic         bad_ck,
	// Track pairs.
	output logic      [1:0]   tape_timing,
	output logic      [1:0]   tape_mark,
	output logic      [5:0]   tape_data_in
	);
	logic [11:0] sum;
	int          i;
	int          b;
	int          j;

	function automatic bit run_ok();
		return tape_motion.go === 1'h1 && tape_motion.fwd === 1'h1 && tape_motion.unit === sel_unit;
	endfunction

	// One line: levels settle first, then the timing pulse; a dropped track must not lose a bit.
	task line(input logic m, input logic [2:0] d);
		tape_mark <= {m & 1'($urandom), m};
		tape_data_in <= {d[0], d[0] & 1'($urandom), d[1], d[1], d[2] & 1'($urandom), d[2]};
		repeat (4) @(posedge link_clk);
		tape_timing <= 2'h3;
		repeat (4) @(posedge link_clk);
		tape_timing <= 2'h0;
	endtask

	// Four lines per word, high bits and the oldest mark bit first.
	task word(input logic [3:0] code, input logic [11:0] v);
		for (j = 0; j < 4; j++)
			if (run_ok())
				line(code[3 - j], v[11 - 3 * j -: 3]);
	endtask

	// Restart the layout at each start; a stopped tape shows the opposite of its last levels.
	initial
	begin
		tape_timing = 2'h0;
		tape_mark = 2'h0;
		tape_data_in = 6'h00;
		forever
		begin
			@(posedge link_clk);
			if (run_ok())
			begin
				repeat (3) word(4'hF, 12'h000);
				for (b = 0; b < 2; b++)
				begin
					sum = 12'h000;
					word(4'hE, blk ^ 12'(1 - b));
					word(4'h2, 12'h000);
					for (i = 0; i < 256; i++)
					begin
						word(i == 255 ? 4'hB : 4'h9, seed ^ 12'(i * 13));
						sum = sum + (seed ^ 12'(i * 13));
					end
					word(4'h1, bad_ck ? sum : ~sum);
					repeat (2) word(4'h1, 12'h000);
					word(4'h7, blk ^ 12'(1 - b));
					repeat (5) word(4'hF, 12'h000);
				end
				while (run_ok()) word(4'h0, 12'h000);
				tape_mark <= ~tape_mark;
				tape_data_in <= ~tape_data_in;
			end
		end
	end
endmodule

// ===== tape_block_format_control_test.sv
// Purpose: Self-checking bench for the tape controller.
// Assumes: Tape model streams whole blocks; memory answers after a random wait.
// Notes:   Seed 19; write-side line patterns are not decoded.
`timescale 1ns/1ns
module tape_block_format_control_test
	import tbfc_pkg::*;
	;
	logic         core_clk = 0, link_clk = 0, srst = 1, core_ce = 1;
	logic         psel = 0, penable = 0, pwrite = 0, mem_ack = 0, tape_wr_enable_n = 1;
	logic         pready, pslverr, mem_req, mem_we, cpu_stall, tape_wr_current, er, bad = 0, wseen = 0;
	logic [11:0]  paddr = 0, mem_rdata = 0, blk = 0, seed = 0, base = 0, mem_addr, mem_wdata;
	logic [31:0]  pwdata = 0, prdata, st;
	logic [1:0]   tape_timing, tape_mark;
	logic [5:0]   tape_data_in;
	logic [2:0]   tape_wr_data, unit = 0;
	tbfc_motion_t tape_motion;
	int           n_errors = 0, tests_run = 0, nst = 0, nft = 0, lat = 0, k, r;

	tbfc_top tbfc_top_i (.core_clk, .srst, .core_ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .cpu_stall,
		.link_clk, .tape_timing, .tape_mark, .tape_data_in, .tape_wr_enable_n, .tape_motion,
		.tape_wr_current, .tape_wr_data);
	tbfc_tape_model tbfc_tape_model_i (.link_clk, .tape_motion, .sel_unit(unit), .blk, .seed, .bad_ck(bad),
		.tape_timing, .tape_mark, .tape_data_in);

	// Core clock at 100 MHz; the link clock runs at 6 ns on an unrelated phase.
	initial forever #5 core_clk = ~core_clk;
	initial
	begin
		#2;
		forever #3 link_clk = ~link_clk;
	end

	task automatic chk(input bit ok, input string m);
		tests_run++;
		if (!ok)
		begin
			n_errors++;
			$display("MISMATCH t=%0t %s", $time, m);
		end
	endtask

	task summarize;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// One register transfer; the request holds until ready is seen at an edge.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		i = 0;
		do
		begin
			@(posedge core_clk);
			i++;
		end
		while (pready !== 1'h1 && i < 9);
		if (pready !== 1'h1)
		begin
			chk(0, "no ready");
			summarize;
		end
		st = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task wait_idle;
		int i;
		for (i = 0; i < 20000; i++)
		begin
			apb(0, 12'h008, 32'h0);
			if (st[0] === 1'h0)
				break;
		end
		if (i == 20000)
		begin
			chk(0, "operation hung");
			summarize;
		end
	endtask

	task start(input logic [2:0] q, input logic [1:0] op, input logic np, input logic [8:0] req);
		nst = 0;
		nft = 0;
		base = 12'(q * 12'h100);
		apb(1, 12'h004, {23'h0, req});
		apb(1, 12'h000, {19'h0, q, np, op, 1'h1, 1'h0, unit, 1'h0, 1'h1});
	endtask

	// Memory answers after 0 to 3 idle cycles; each stolen cycle is compared as it completes.
	always @(posedge core_clk)
	begin
		if (mem_ack)
			mem_ack <= 0;
		else if (mem_req && lat > 0)
			lat <= lat - 1;
		else if (mem_req)
		begin
			mem_ack <= 1;
			lat <= $urandom % 4;
			mem_rdata <= 12'($urandom);
		end
		if (mem_req === 1'h1 && mem_ack === 1'h1)
		begin
			chk(mem_addr === 12'(base + nst + nft), "memory address");
			if (mem_we)
			begin
				chk(mem_wdata === (seed ^ 12'(nst * 13)), "stored word");
				nst++;
			end
			else
				nft++;
		end
	end

	always @(posedge link_clk)
		if (tape_wr_current === 1'h1)
			wseen <= 1;

	initial
	begin
		k = $urandom(19);
		repeat (5) @(posedge core_clk);
		srst <= 0;
		@(posedge core_clk);
		chk(pready === 1'h0 && mem_req === 1'h0 && cpu_stall === 1'h0 && tape_motion.stop === 1'h1, "reset");
		apb(0, 12'h00C, 32'h0);
		chk(er === 1'h1 && st === 32'h0, "unmapped read");
		apb(0, 12'h000, 32'h0);
		chk(st[0] === 1'h0, "start reads zero");
		$display("test registers done");
		for (r = 0; r < 2; r++)
		begin
			seed = 12'($urandom);
			blk = 12'($urandom % 500 + 2);
			unit = 3'($urandom);
			bad = r[0];
			start(3'($urandom), 2'h0, r[0], blk[8:0]);
			repeat (30) @(posedge core_clk);
			chk(cpu_stall === !r[0], "stall level");
			wait_idle;
			chk(nst === 256 && st[2:1] === {r[0], 1'h1} && st[27:16] === blk, "read result");
			chk(cpu_stall === 1'h0, "stall after done");
			apb(1, 12'h008, 32'h2);
			apb(0, 12'h008, 32'h0);
			chk(st[1] === 1'h0, "done cleared");
			$display("test read %0d done", r);
		end
		tape_wr_enable_n <= 0;
		bad = 0;
		start(3'h7, 2'h1, 1'h0, blk[8:0]);
		wait_idle;
		chk(nft === 256 && wseen === 1'h1, "write fetches");
		tape_wr_enable_n <= 1;
		$display("test write done");
		blk = 12'h200;
		start(3'h0, 2'h0, 1'h0, 9'h001);
		for (k = 0; k < 20000 && !(k > 50 && tape_motion.go === 1'h0); k++)
			@(posedge core_clk);
		wait_idle;
		chk(k < 20000 && nst === 0 && st[3] === 1'h1 && st[5] === 1'h1, "end zone stop");
		$display("test end zone done");
		apb(1, 12'h008, 32'h2);
		blk = 12'h0FF;
		start(3'h2, 2'h0, 1'h0, blk[8:0]);
		repeat (50) @(posedge core_clk);
		apb(1, 12'h000, 32'h2);
		repeat (20) @(posedge core_clk);
		chk(tape_motion.all_halt === 1'h1 && tape_motion.stop === 1'h1, "halt levels");
		wait_idle;
		chk(st[4] === 1'h1 && st[1] === 1'h1, "halted status");
		$display("test halt done");
		summarize;
	end
endmodule

bind tbfc_top tbfc_sva tbfc_sva_i (.core_clk, .srst, .psel, .penable, .pready, .pslverr, .mem_req, .mem_ack,
	.mem_addr, .mem_we, .link_clk, .tape_wr_enable_n, .tape_motion, .tape_wr_current);
